// file: src/twowire_pkg.sv
// Purpose: Shared types and constants of the two-wire control/status block
// Assumes: One 8-bit special function register, bit-addressable
// Notes:   Struct field order matches register bit order, bit 7 first

package twowire_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_STATUS_ADDR = 8'hC0;
    localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Bit 7 down to bit 0 of the control/status register
    typedef struct packed {
        logic master;
        logic tx_dir;
        logic start;
        logic stop;
        logic ack_needed;
        logic arb_lost;
        logic ack;
        logic event_pend;
    } ctrl_status_t;

    // ------------------------------------------------------------------
    // Link-side event pulses from the bit engine
    // ------------------------------------------------------------------
    typedef struct packed {
        logic start_gen;
        logic stop_gen;
        logic addr_rx;
        logic tx_ack;
        logic tx_nack;
        logic byte_rx;
        logic frame_begin;
        logic ack_done;
    } eng_pulse_t;

    // Events that cross into the system clock domain
    typedef struct packed {
        eng_pulse_t eng;
        logic start_det;
        logic stop_det;
        logic arb_lost;
    } link_event_t;

    localparam int EV_W = $bits(link_event_t);
    localparam logic [EV_W-1:0] EV_NONE = '0;

    // Levels from the system domain to the link side
    typedef struct packed {
        logic start_req;
        logic stop_req;
        logic ack_send;
        logic hold_scl;
    } link_ctrl_t;

    localparam int CTRL_W = $bits(link_ctrl_t);
    localparam logic [CTRL_W-1:0] CTRL_NONE = '0;

endpackage

// file: src/twowire_link_monitor.sv
// Purpose: Link-clock side: pin sampling, START/STOP, arbitration, SCL hold
// Assumes: clk_link runs freely and oversamples SCL and SDA
// Notes:   Every event leaves this domain as a toggle

`timescale 1ns/10ps
`default_nettype none

module twowire_link_monitor (
    input wire logic clk_link,
    input wire logic rst_b,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire twowire_pkg::eng_pulse_t eng_pulse,
    input wire logic eng_drive_one,
    input wire logic eng_ack_slot,
    input wire logic eng_attempt_ss,
    input wire twowire_pkg::link_ctrl_t ctrl_i,
    output twowire_pkg::link_ctrl_t ctrl_o,
    output logic scl_o,
    output logic scl_oe,
    output logic [twowire_pkg::EV_W-1:0] ev_tog,
    output logic bus_busy
);

    typedef enum logic {BUS_IDLE = 1'b0, BUS_BUSY = 1'b1} bus_state_t;

    logic [1:0] scl_s_q, sda_s_q;
    logic scl_prev_q, sda_prev_q;
    logic [twowire_pkg::CTRL_W-1:0] ctrl_s1_q, ctrl_s2_q;
    logic arb_cond, arb_cond_q;
    logic start_det, stop_det;
    bus_state_t state_q;
    twowire_pkg::link_event_t ev_now;

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_link or negedge rst_b) begin
        if (!rst_b) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_i};
            sda_s_q <= {sda_s_q[0], sda_i};
            scl_prev_q <= scl_s_q[1];
            sda_prev_q <= sda_s_q[1];
        end
    end

    always_ff @(posedge clk_link or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_s1_q <= twowire_pkg::CTRL_NONE;
            ctrl_s2_q <= twowire_pkg::CTRL_NONE;
        end else begin
            ctrl_s1_q <= ctrl_i;
            ctrl_s2_q <= ctrl_s1_q;
        end
    end

    assign ctrl_o = ctrl_s2_q;
    assign scl_o = 1'b0;
    assign scl_oe = ctrl_o.hold_scl; // [R14]

    // ------------------------------------------------------------------
    // Bus conditions
    // ------------------------------------------------------------------
    assign start_det = scl_s_q[1] && scl_prev_q && sda_prev_q && !sda_s_q[1];
    assign stop_det = scl_s_q[1] && scl_prev_q && !sda_prev_q && sda_s_q[1];
    // SDA compare is a sampled check; the engine keeps drive_one to SCL high
    assign arb_cond = (eng_attempt_ss && !scl_s_q[1]) ||
        (eng_drive_one && !eng_ack_slot && !sda_s_q[1]); // [R9]

    always_ff @(posedge clk_link or negedge rst_b) begin
        if (!rst_b) begin
            arb_cond_q <= 1'b0;
        end else begin
            arb_cond_q <= arb_cond;
        end
    end

    always_ff @(posedge clk_link or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= BUS_IDLE;
        end else begin
            unique case (state_q)
                BUS_IDLE: if (start_det) state_q <= BUS_BUSY;
                BUS_BUSY: if (stop_det) state_q <= BUS_IDLE;
            endcase
        end
    end

    assign bus_busy = (state_q == BUS_BUSY);

    always_comb begin
        ev_now.eng = eng_pulse;
        ev_now.start_det = start_det;
        ev_now.stop_det = stop_det;
        ev_now.arb_lost = arb_cond && !arb_cond_q;
    end

    always_ff @(posedge clk_link or negedge rst_b) begin
        if (!rst_b) begin
            ev_tog <= twowire_pkg::EV_NONE;
        end else begin
            ev_tog <= ev_tog ^ ev_now;
        end
    end

endmodule // twowire_link_monitor

`default_nettype wire

// file: src/twowire_bus_control_status.sv
// Purpose: Control/status register of the two-wire serial interface
// Assumes: Bit engine on clk_link reports events; CPU uses the SFR port
// Notes:   Bit-addressable writes arrive as a per-bit write mask
//
// Overview of operation
// R1: Role bit set by START, cleared by STOP/arbitration
// R2: Direction bit: 0 receive, 1 transmit
// R3: Direction follows START and data write before frame
// R4: Start bit written 1 as controller launches START
// R5: Start bit set on START plus address; software clears
// R6: Stop bit launches STOP; cleared once generated
// R7: Stop bit set on target STOP or STOP loss
// R8: Ack-needed set on software-acked byte; cleared per ack
// R9: Arbitration lost on three listed bus conditions
// R10: Arbitration flag cleared when software clears event flag
// R11: Read ack bit is 1 for received ACK
// R12: Written ack bit chooses ACK or NACK response
// R13: Event flag set by seven bus events
// R14: SCL held low while event flag set
// R15: Software clears event flag; writing 1 forces it
// R16: Interrupt reaches CPU only when enable bit is 1
// R17: All bits reset to 0; read-only writes ignored

`timescale 1ns/10ps
`default_nettype none

module twowire_bus_control_status (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_link,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire twowire_pkg::ctrl_status_t sfr_wmask,
    input wire twowire_pkg::ctrl_status_t sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic data_reg_wr,
    input wire logic hw_ack_enable,
    input wire logic twowire_irq_enable,
    output logic irq,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe,
    input wire twowire_pkg::eng_pulse_t eng_pulse,
    input wire logic eng_drive_one,
    input wire logic eng_ack_slot,
    input wire logic eng_attempt_ss,
    output twowire_pkg::link_ctrl_t eng_ctrl
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    twowire_pkg::ctrl_status_t reg_q;
    twowire_pkg::ctrl_status_t wm;
    twowire_pkg::link_ctrl_t ctrl_q;
    twowire_pkg::link_ctrl_t ctrl_d;
    twowire_pkg::link_event_t ev;
    logic [twowire_pkg::EV_W-1:0] ev_tog;
    logic [twowire_pkg::EV_W-1:0] ev_s1_q, ev_s2_q, ev_s3_q;
    logic busy_link, busy_s1_q, busy_s2_q;
    logic wr_hit;
    logic wr_before_q;
    logic addressed_q;
    logic arb_any;
    logic foreign_start;
    logic slave_stop;
    logic arb_stop;
    logic si_sw_clear;
    logic si_set;
    logic rdata_q;
    logic [7:0] rdata_byte_q;
    logic irq_q;

    // ------------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------------
    twowire_link_monitor u_link (
        .clk_link(clk_link),
        .rst_b(rst_b),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .eng_pulse(eng_pulse),
        .eng_drive_one(eng_drive_one),
        .eng_ack_slot(eng_ack_slot),
        .eng_attempt_ss(eng_attempt_ss),
        .ctrl_i(ctrl_q),
        .ctrl_o(eng_ctrl),
        .scl_o(scl_o),
        .scl_oe(scl_oe),
        .ev_tog(ev_tog),
        .bus_busy(busy_link)
    );

    // ------------------------------------------------------------------
    // Event and level crossing into clk_sys
    // ------------------------------------------------------------------
    // Third stage only feeds the edge compare, never the first stage
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ev_s1_q <= twowire_pkg::EV_NONE;
            ev_s2_q <= twowire_pkg::EV_NONE;
            ev_s3_q <= twowire_pkg::EV_NONE;
        end else begin
            ev_s1_q <= ev_tog;
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
        end
    end

    assign ev = ev_s2_q ^ ev_s3_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy_s1_q <= 1'b0;
            busy_s2_q <= 1'b0;
        end else begin
            busy_s1_q <= busy_link;
            busy_s2_q <= busy_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------
    assign wr_hit = sfr_wr && (sfr_addr == twowire_pkg::CTRL_STATUS_ADDR);
    assign wm = wr_hit ? sfr_wmask : twowire_pkg::CTRL_STATUS_RESET;
    assign si_sw_clear = wm.event_pend && !sfr_wdata.event_pend;

    // ------------------------------------------------------------------
    // Derived bus conditions
    // ------------------------------------------------------------------
    // Our own START is also seen on the pins; only an unrequested one counts
    assign foreign_start = ev.start_det && !reg_q.start;
    assign slave_stop = ev.stop_det && !reg_q.master && addressed_q;
    assign arb_stop = ev.stop_det && reg_q.master && !reg_q.stop;
    assign arb_any = ev.arb_lost || arb_stop ||
        (foreign_start && reg_q.master); // [R9]
    assign si_set = ev.eng.start_gen || arb_any || ev.eng.tx_ack ||
        ev.eng.tx_nack || ev.eng.byte_rx || ev.eng.addr_rx ||
        slave_stop; // [R13]

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            addressed_q <= 1'b0;
        end else if (ev.eng.addr_rx) begin
            addressed_q <= 1'b1;
        end else if (ev.stop_det) begin
            addressed_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Role and direction
    // ------------------------------------------------------------------
    // Read-only bits take no software write at all
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_q.master <= 1'b0; // [R17]
        end else if (ev.eng.start_gen) begin
            reg_q.master <= 1'b1; // [R1]
        end else if (ev.eng.stop_gen || arb_any) begin
            reg_q.master <= 1'b0; // [R1]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_before_q <= 1'b0;
        end else if (data_reg_wr) begin
            wr_before_q <= 1'b1;
        end else if (ev.eng.frame_begin) begin
            wr_before_q <= 1'b0;
        end
    end

    // Transmit when the data register was loaded before the frame
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_q.tx_dir <= 1'b0;
        end else if (ev.eng.start_gen ||
                     (ev.eng.frame_begin && wr_before_q)) begin
            reg_q.tx_dir <= 1'b1; // [R2] [R3]
        end else if (foreign_start || arb_any ||
                     (ev.eng.frame_begin && !wr_before_q)) begin
            reg_q.tx_dir <= 1'b0; // [R2] [R3]
        end
    end

    // ------------------------------------------------------------------
    // Start and stop flags
    // ------------------------------------------------------------------
    // Hardware set beats a software clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_q.start <= 1'b0;
        end else if (ev.eng.addr_rx) begin
            reg_q.start <= 1'b1; // [R5]
        end else if (wm.start) begin
            reg_q.start <= sfr_wdata.start; // [R4]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_q.stop <= 1'b0;
        end else if (slave_stop || arb_stop) begin
            reg_q.stop <= 1'b1; // [R7]
        end else if (ev.eng.stop_gen) begin
            reg_q.stop <= 1'b0; // [R6]
        end else if (wm.stop) begin
            reg_q.stop <= sfr_wdata.stop; // [R6]
        end
    end

    // ------------------------------------------------------------------
    // Acknowledge handling
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_q.ack_needed <= 1'b0;
        end else if (ev.eng.byte_rx && !hw_ack_enable) begin
            reg_q.ack_needed <= 1'b1; // [R8]
        end else if (ev.eng.ack_done) begin
            reg_q.ack_needed <= 1'b0; // [R8]
        end
    end

    // Received ACK overrides a software write landing in the same cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_q.ack <= 1'b0;
        end else if (ev.eng.tx_ack) begin
            reg_q.ack <= 1'b1; // [R11]
        end else if (ev.eng.tx_nack) begin
            reg_q.ack <= 1'b0; // [R11]
        end else if (wm.ack) begin
            reg_q.ack <= sfr_wdata.ack; // [R12]
        end
    end

    // ------------------------------------------------------------------
    // Arbitration and event flag
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_q.arb_lost <= 1'b0;
        end else if (arb_any) begin
            reg_q.arb_lost <= 1'b1; // [R9]
        end else if (si_sw_clear) begin
            reg_q.arb_lost <= 1'b0; // [R10]
        end
    end

    // Clearing releases the SCL hold, which lets the engine move on
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_q.event_pend <= 1'b0;
        end else if (si_set) begin
            reg_q.event_pend <= 1'b1; // [R13]
        end else if (wm.event_pend) begin
            reg_q.event_pend <= sfr_wdata.event_pend; // [R15]
        end
    end

    // ------------------------------------------------------------------
    // Requests to the link side
    // ------------------------------------------------------------------
    // Registered so that only glitch-free levels cross the clock boundary
    always_comb begin
        ctrl_d.start_req = reg_q.start &&
            (reg_q.master || !busy_s2_q); // [R4]
        ctrl_d.stop_req = reg_q.stop && reg_q.master; // [R6]
        ctrl_d.ack_send = reg_q.ack; // [R12]
        ctrl_d.hold_scl = reg_q.event_pend; // [R14]
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= twowire_pkg::CTRL_NONE;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt and read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= reg_q.event_pend && twowire_irq_enable; // [R16]
        end
    end

    assign irq = irq_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 1'b0;
            rdata_byte_q <= twowire_pkg::READ_IDLE;
        end else begin
            rdata_q <= sfr_rd &&
                (sfr_addr == twowire_pkg::CTRL_STATUS_ADDR);
            rdata_byte_q <= reg_q;
        end
    end

    assign sfr_rdata = rdata_q ? rdata_byte_q : twowire_pkg::READ_IDLE;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Every check below lives on clk_sys and pauses while reset is low
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    a_role_on_start: assert property ( // [R1]
        ev.eng.start_gen |=> reg_q.master)
        else $error("role bit not set after START generated");
    a_role_on_loss: assert property ( // [R1]
        arb_any && !ev.eng.start_gen |=> !reg_q.master && reg_q.arb_lost)
        else $error("role bit kept after arbitration loss");
    a_txdir_frame: assert property ( // [R3]
        ev.eng.frame_begin && !wr_before_q && !ev.eng.start_gen
        |=> !reg_q.tx_dir)
        else $error("direction not cleared without data write");
    a_start_launch: assert property ( // [R4]
        reg_q.start && reg_q.master |=> ctrl_q.start_req)
        else $error("start request not passed to link");
    a_start_sticky: assert property ( // [R5]
        reg_q.start && !(wm.start && !sfr_wdata.start) |=> reg_q.start)
        else $error("start flag cleared by hardware");
    a_stop_done: assert property ( // [R6]
        ev.eng.stop_gen && !slave_stop && !arb_stop |=> !reg_q.stop)
        else $error("stop flag not cleared after STOP");
    a_ackreq_set: assert property ( // [R8]
        ev.eng.byte_rx && !hw_ack_enable |=> reg_q.ack_needed)
        else $error("ack request not raised");
    a_arb_clear: assert property ( // [R10]
        si_sw_clear && !arb_any |=> !reg_q.arb_lost)
        else $error("arbitration flag survived event clear");
    a_ack_read: assert property ( // [R11]
        ev.eng.tx_nack && !ev.eng.tx_ack |=> !reg_q.ack)
        else $error("NACK not reflected in ack bit");
    a_event_set: assert property ( // [R13]
        si_set |=> reg_q.event_pend)
        else $error("event flag not set by bus event");
    a_hold_scl: assert property ( // [R14]
        $rose(reg_q.event_pend) |=> ctrl_q.hold_scl)
        else $error("SCL hold not requested");
    a_irq_gate: assert property ( // [R16]
        irq |-> $past(reg_q.event_pend && twowire_irq_enable))
        else $error("interrupt raised while disabled");
    a_ro_ignored: assert property ( // [R17]
        wm.master && !ev.eng.start_gen && !ev.eng.stop_gen && !arb_any
        |=> $stable(reg_q.master))
        else $error("write changed read-only role bit");

endmodule // twowire_bus_control_status

`default_nettype wire

// file: dv/twowire_peer_model.sv
// Purpose: Far side: bit engine pulses and bus pins on the link clock
// Assumes: Requests come as a toggle with a held pulse pattern
// Notes:   Pins are open drain with pull-ups
`timescale 1ns/10ps
`default_nettype none
module twowire_peer_model (
    input wire logic clk_link,
    input wire logic rst_b,
    input wire twowire_pkg::eng_pulse_t req,
    input wire logic req_tog,
    input wire logic arb_req,
    input wire logic sda_low,
    input wire logic scl_oe,
    output twowire_pkg::eng_pulse_t eng_pulse,
    output logic eng_drive_one,
    output logic scl_i,
    output logic sda_i
);
    logic [2:0] tog_q;
    // Resynchronised toggle, so one request gives exactly one pulse
    always_ff @(posedge clk_link or negedge rst_b) begin
        if (!rst_b) begin
            tog_q <= '0;
            eng_pulse <= '0;
        end else begin
            tog_q <= {tog_q[1:0], req_tog};
            eng_pulse <= (tog_q[2] != tog_q[1]) ? req : '0;
        end
    end
    // Engine sends a 1 while a peer pulls SDA low
    assign eng_drive_one = arb_req;
    // A peer may also pull SDA on its own to frame START and STOP
    assign sda_i = !(arb_req || sda_low);
    // Wired SCL: a device hold beats the pull-up
    assign scl_i = !scl_oe;
endmodule // twowire_peer_model
`default_nettype wire

// file: dv/test_twowire_bus_control_status.sv
// Purpose: Register-level regression of the control/status block
// Assumes: Peer model stands in for the bit engine and the bus
// Notes:   Link settle waits cover sync plus 3-4 sys edges
`timescale 1ns/10ps
`default_nettype none
module test_twowire_bus_control_status;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic hw_ack = 1'b0;
    logic irq_en = 1'b0;
    logic req_tog = 1'b0;
    logic arb_req = 1'b0;
    logic data_wr = 1'b0;
    logic ss = 1'b0;
    logic sda_low = 1'b0;
    logic [7:0] sfr_rdata;
    logic irq, scl_i, sda_i, scl_o, scl_oe, drive_one;
    twowire_pkg::ctrl_status_t wmask = '0;
    twowire_pkg::ctrl_status_t wdata = '0;
    twowire_pkg::eng_pulse_t req = '0;
    twowire_pkg::eng_pulse_t eng_pulse;
    twowire_pkg::link_ctrl_t eng_ctrl;
    int n_fail = 0;
    int tests_run = 0;
    localparam logic [7:0] A = twowire_pkg::CTRL_STATUS_ADDR;
    always #4 clk_sys = ~clk_sys;
    initial begin
        #3.3;
        forever #24 clk_link = ~clk_link;
    end
    twowire_bus_control_status twowire_bus_control_status_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .clk_link(clk_link),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wmask(wmask),
        .sfr_wdata(wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .data_reg_wr(data_wr), .hw_ack_enable(hw_ack),
        .twowire_irq_enable(irq_en), .irq(irq), .scl_i(scl_i),
        .sda_i(sda_i), .scl_o(scl_o), .scl_oe(scl_oe), .eng_pulse(eng_pulse),
        .eng_drive_one(drive_one), .eng_ack_slot(1'b0),
        .eng_attempt_ss(ss), .eng_ctrl(eng_ctrl));
    twowire_peer_model twowire_peer_model_i (
        .clk_link(clk_link), .rst_b(rst_b), .req(req), .req_tog(req_tog),
        .arb_req(arb_req), .sda_low(sda_low), .scl_oe(scl_oe),
        .eng_pulse(eng_pulse), .eng_drive_one(drive_one), .scl_i(scl_i),
        .sda_i(sda_i));
    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] m, d);
        @(negedge clk_sys);
        sfr_addr = A;
        wmask = m;
        wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, m, exp);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        chk("ctrl_status", sfr_rdata & m, exp);
    endtask
    task automatic ev(input logic [7:0] p);
        req = p;
        req_tog = ~req_tog;
        repeat (60) @(negedge clk_sys);
    endtask
    task automatic summarize();
        $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
    initial begin
        repeat (12) @(negedge clk_sys);
        rst_b = 1'b1;
        rc(A, 8'hFF, 8'h00);
        rc(8'h55, 8'hFF, 8'h00);
        wr(8'hFF, 8'hCC);
        rc(A, 8'hFF, 8'h00);
        wr(8'h01, 8'h01);
        rc(A, 8'hFF, 8'h01);
        chk("irq", {7'h00, irq}, 8'h00);
        irq_en = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("irq", {7'h00, irq}, 8'h01);
        repeat (30) @(negedge clk_sys);
        chk("scl_oe", {7'h00, scl_oe}, 8'h01);
        chk("scl_o", {7'h00, scl_o}, 8'h00);
        wr(8'h01, 8'h00);
        rc(A, 8'hFF, 8'h00);
        repeat (30) @(negedge clk_sys);
        chk("scl_oe", {7'h00, scl_oe}, 8'h00);
        ev(8'h04);
        rc(A, 8'hFF, 8'h09);
        ev(8'h01);
        rc(A, 8'h08, 8'h00);
        wr(8'h01, 8'h00);
        hw_ack = 1'b1;
        ev(8'h04);
        rc(A, 8'h09, 8'h01);
        hw_ack = 1'b0;
        wr(8'h01, 8'h00);
        ev(8'h10);
        rc(A, 8'h03, 8'h03);
        wr(8'h01, 8'h00);
        ev(8'h08);
        rc(A, 8'h03, 8'h01);
        wr(8'h03, 8'h02);
        repeat (30) @(negedge clk_sys);
        chk("ack_send", {7'h00, eng_ctrl.ack_send}, 8'h01);
        wr(8'h23, 8'h20);
        repeat (30) @(negedge clk_sys);
        chk("start_req", {7'h00, eng_ctrl.start_req}, 8'h01);
        ev(8'h80);
        rc(A, 8'hFF, 8'hE1);
        wr(8'h11, 8'h10);
        repeat (30) @(negedge clk_sys);
        chk("stop_req", {7'h00, eng_ctrl.stop_req}, 8'h01);
        ev(8'h40);
        rc(A, 8'h90, 8'h00);
        wr(8'h21, 8'h00);
        arb_req = 1'b1;
        repeat (60) @(negedge clk_sys);
        arb_req = 1'b0;
        rc(A, 8'h05, 8'h05);
        wr(8'h01, 8'h00);
        rc(A, 8'h04, 8'h00);
        ev(8'h20);
        rc(A, 8'hFF, 8'h21);
        wr(8'h01, 8'h00);
        // Bus released again, then a peer frames START and STOP
        repeat (40) @(negedge clk_sys);
        sda_low = 1'b1;
        repeat (30) @(negedge clk_sys);
        sda_low = 1'b0;
        repeat (60) @(negedge clk_sys);
        rc(A, 8'hFF, 8'h31);
        wr(8'h31, 8'h00);
        data_wr = 1'b1;
        @(negedge clk_sys);
        data_wr = 1'b0;
        ev(8'h02);
        rc(A, 8'h40, 8'h40);
        ev(8'h02);
        rc(A, 8'h40, 8'h00);
        wr(8'h01, 8'h01);
        repeat (40) @(negedge clk_sys);
        ss = 1'b1;
        repeat (30) @(negedge clk_sys);
        ss = 1'b0;
        rc(A, 8'h04, 8'h04);
        wr(8'h01, 8'h00);
        rc(A, 8'h04, 8'h00);
        summarize();
    end
endmodule // test_twowire_bus_control_status
`default_nettype wire
